// ---- verilog/gyro_cfg_regs.sv ----
// Purpose: configuration registers, sample timing, bias removal, buffer
// Assumes: serial bus pins arrive asynchronously and are synchronised
// Notes:   secondary-bus transfers are run by an engine on accel_read_req
`timescale 1ns/10ps
`include "gyro_defs.svh"

module gyro_cfg_regs #(
  parameter int          CLK_HZ   = `CLK_HZ,
  parameter int          CYC_1K   = CLK_HZ / `RATE_1K_HZ,
  parameter int          CYC_8K   = CLK_HZ / `RATE_8K_HZ,
  parameter int          DEPTH    = `FIFO_BYTES,
  parameter logic [15:0] TRAILER  = 16'h0000,
  parameter logic [5:0]  OWN_RST  = 6'h2a // arbitrary value
) (
  input  wire logic        clk,            // 25 MHz
  input  wire logic        rst,            // sync, active high
  input  wire logic        ce,             // freezes state when low
  input  wire logic        scl_in,         // serial clock pin
  input  wire logic        sda_in,         // serial data pin level
  output logic             sda_out,        // driven level, always 0
  output logic             sda_oe_n,       // low while pulling sda
  input  wire logic        addr_lsb_in,    // address strap pin
  input  wire logic [15:0] raw_gyro_x,     // raw samples
  input  wire logic [15:0] raw_gyro_y,
  input  wire logic [15:0] raw_gyro_z,
  input  wire logic [15:0] raw_temp,
  input  wire logic        aux_if_en,      // secondary interface enable
  input  wire logic        aux_if_rst,     // secondary interface reset
  input  wire logic        accel_valid,    // accel words ready
  input  wire logic [15:0] accel_x,        // accel words read back
  input  wire logic [15:0] accel_y,
  input  wire logic [15:0] accel_z,
  output logic             accel_read_req, // start secondary burst
  output logic [6:0]       accel_bus_address, // applied target
  output logic [15:0]      gyro_x_out,     // sensor outputs
  output logic [15:0]      gyro_y_out,
  output logic [15:0]      gyro_z_out,
  output logic [15:0]      temp_out,
  output logic [15:0]      accel_x_out,
  output logic [15:0]      accel_y_out,
  output logic [15:0]      accel_z_out,
  output logic             sample_tick,    // one pulse per sample
  input  wire logic        fifo_rd,        // pop one byte
  output logic [7:0]       fifo_rdata,     // popped byte
  output logic [9:0]       fifo_count,     // bytes held
  output logic             fifo_overflow,  // sticky, push lost
  output logic [1:0]       range_select,   // 0..3 = 250..2000 dps
  output logic [2:0]       filter_select,  // bandwidth code
  output logic             secondary_level_select, // 1 main, 0 io rail
  output logic             ref_clock_out_pin       // reference clock
);
  localparam int AW = $clog2(DEPTH);

  logic [7:0]  id_r, xbh_r, xbl_r, ybh_r, ybl_r, zbh_r, zbl_r;
  logic [7:0]  fsel_r, level_r, acca_r, div_r, filt_r;
  logic [7:0]  ptr_r, sh_r, tx_r;
  logic [3:0]  bits_r;
  logic        rw_r, first_r, nack_r, drv_r;
  gyro_pkg::ser_state_e st_r;
  logic        scl_m_r, scl_s_r, scl_q_r, sda_m_r, sda_s_r, sda_q_r;
  logic        lsb_m_r, lsb_s_r;
  logic [15:0] int_cnt_r, ax_r, ay_r, az_r;
  logic [7:0]  div_cnt_r;
  logic        seq_act_r, seq_lo_r, ref_r, req_r, ovf_r;
  logic [2:0]  seq_bit_r;
  logic [7:0]  seq_sel_r, rdata_r;
  logic [7:0]  mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [9:0]  cnt_r;
  logic [15:0] gx_r, gy_r, gz_r, tp_r, axo_r, ayo_r, azo_r;
  logic [6:0]  acc_live_r;

  // serial pin synchronisers; the first stage never feeds logic, the later stages do
  always_ff @(posedge clk) begin
    if (rst) begin
      {scl_m_r, scl_s_r, scl_q_r} <= 3'b111;
      {sda_m_r, sda_s_r, sda_q_r} <= 3'b111;
      {lsb_m_r, lsb_s_r}          <= 2'b00;
    end else if (ce) begin
      {scl_m_r, scl_s_r, scl_q_r} <= {scl_in, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_q_r} <= {sda_in, sda_m_r, sda_s_r};
      {lsb_m_r, lsb_s_r}          <= {addr_lsb_in, lsb_m_r};
    end
  end

  wire scl_rise = scl_s_r & ~scl_q_r;
  wire scl_fall = ~scl_s_r & scl_q_r;
  wire start_c  = scl_s_r & scl_q_r & ~sda_s_r & sda_q_r;
  wire stop_c   = scl_s_r & scl_q_r & sda_s_r & ~sda_q_r;
  wire rx_phase = (st_r == gyro_pkg::ST_ADDR) ||
                  (st_r == gyro_pkg::ST_WDATA);
  wire addr_hit = sh_r[7:1] == {id_r[6:1], lsb_s_r};
  wire wr_fire  = ce & scl_fall & ~start_c & ~stop_c & ~first_r &
                  (st_r == gyro_pkg::ST_WDATA) & (bits_r == `BYTE_BITS);

  // burst pointer holds at the two stop registers
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = (p == `PTR_STOP_A || p == `PTR_STOP_B) ? p : p + 8'h01;
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      `OFS_ID:    reg_read = id_r;
      `OFS_XBH:   reg_read = xbh_r;
      `OFS_XBL:   reg_read = xbl_r;
      `OFS_YBH:   reg_read = ybh_r;
      `OFS_YBL:   reg_read = ybl_r;
      `OFS_ZBH:   reg_read = zbh_r;
      `OFS_ZBL:   reg_read = zbl_r;
      `OFS_FSEL:  reg_read = fsel_r;
      `OFS_LEVEL: reg_read = level_r;
      `OFS_ACCA:  reg_read = acca_r;
      `OFS_DIV:   reg_read = div_r;
      `OFS_FILT:  reg_read = filt_r;
      default:    reg_read = `RST_BYTE;
    endcase
  endfunction

  wire [7:0] rd_byte = reg_read(ptr_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r    <= gyro_pkg::ST_IDLE;
      bits_r  <= 4'h0;
      sh_r    <= `RST_BYTE;
      tx_r    <= `RST_BYTE;
      ptr_r   <= `RST_BYTE;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
      nack_r  <= 1'b0;
      drv_r   <= 1'b0;
    end else if (ce) begin
      if (start_c) begin
        st_r   <= gyro_pkg::ST_ADDR;
        bits_r <= 4'h0;
        drv_r  <= 1'b0;
      end else if (stop_c) begin
        st_r  <= gyro_pkg::ST_IDLE;
        drv_r <= 1'b0;
      end else begin
        if (scl_rise && rx_phase) begin
          sh_r   <= {sh_r[6:0], sda_s_r};
          bits_r <= bits_r + 4'h1;
        end
        if (scl_rise && st_r == gyro_pkg::ST_RACK)
          nack_r <= sda_s_r;
        if (scl_fall) begin
          unique case (st_r)
            gyro_pkg::ST_IDLE: ;
            gyro_pkg::ST_ADDR: if (bits_r == `BYTE_BITS) begin
              if (addr_hit) begin
                rw_r  <= sh_r[0];
                drv_r <= 1'b1;
                st_r  <= gyro_pkg::ST_AACK;
              end else
                st_r  <= gyro_pkg::ST_IDLE;
            end
            gyro_pkg::ST_AACK: begin
              bits_r <= 4'h0;
              if (rw_r) begin
                tx_r  <= rd_byte;
                drv_r <= ~rd_byte[7];
                st_r  <= gyro_pkg::ST_RDATA;
              end else begin
                drv_r   <= 1'b0;
                first_r <= 1'b1;
                st_r    <= gyro_pkg::ST_WDATA;
              end
            end
            gyro_pkg::ST_WDATA: if (bits_r == `BYTE_BITS) begin
              drv_r   <= 1'b1;
              first_r <= 1'b0;
              st_r    <= gyro_pkg::ST_WACK;
              ptr_r   <= first_r ? sh_r : next_ptr(ptr_r);
            end
            gyro_pkg::ST_WACK: begin
              drv_r  <= 1'b0;
              bits_r <= 4'h0;
              st_r   <= gyro_pkg::ST_WDATA;
            end
            gyro_pkg::ST_RDATA: if (bits_r == `LAST_TX_BIT) begin
              drv_r  <= 1'b0;
              bits_r <= 4'h0;
              ptr_r  <= next_ptr(ptr_r);
              st_r   <= gyro_pkg::ST_RACK;
            end else begin
              tx_r   <= {tx_r[6:0], 1'b0};
              drv_r  <= ~tx_r[6];
              bits_r <= bits_r + 4'h1;
            end
            gyro_pkg::ST_RACK: if (nack_r)
              st_r <= gyro_pkg::ST_IDLE;
            else begin
              tx_r  <= rd_byte;
              drv_r <= ~rd_byte[7];
              st_r  <= gyro_pkg::ST_RDATA;
            end
          endcase
        end
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drv_r;

  // undefined bits are not stored, so they read back as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      id_r    <= {1'b0, OWN_RST, 1'b0};
      {xbh_r, xbl_r, ybh_r, ybl_r} <= {4{`RST_BYTE}};
      {zbh_r, zbl_r, fsel_r}       <= {3{`RST_BYTE}};
      {level_r, acca_r, div_r}     <= {3{`RST_BYTE}};
      filt_r  <= `RST_BYTE;
    end else if (wr_fire) begin
      unique case (ptr_r)
        `OFS_ID:    id_r    <= {1'b0, sh_r[6:1], 1'b0};
        `OFS_XBH:   xbh_r   <= sh_r;
        `OFS_XBL:   xbl_r   <= sh_r;
        `OFS_YBH:   ybh_r   <= sh_r;
        `OFS_YBL:   ybl_r   <= sh_r;
        `OFS_ZBH:   zbh_r   <= sh_r;
        `OFS_ZBL:   zbl_r   <= sh_r;
        `OFS_FSEL:  fsel_r  <= sh_r;
        `OFS_LEVEL: level_r <= sh_r & (8'h01 << `LEVEL_BIT);
        `OFS_ACCA:  acca_r  <= sh_r;
        `OFS_DIV:   div_r   <= sh_r;
        `OFS_FILT:  filt_r  <= sh_r & `FILT_MASK;
        default: ;
      endcase
    end
  end

  assign range_select           = filt_r[4:3];
  assign filter_select          = filt_r[2:0];
  assign secondary_level_select = level_r[`LEVEL_BIT];

  // internal tick: 8 kHz only for filter code 0, 1 kHz otherwise
  wire [15:0] int_lim = (filt_r[2:0] == `FILT_8K) ?
                        16'(CYC_8K - 1) : 16'(CYC_1K - 1);
  wire int_tick  = ce & (int_cnt_r >= int_lim);
  wire samp_stb  = int_tick & (div_cnt_r >= div_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      int_cnt_r <= 16'h0000;
      div_cnt_r <= `RST_BYTE;
    end else if (ce) begin
      int_cnt_r <= int_tick ? 16'h0000 : int_cnt_r + 16'h0001;
      if (int_tick)
        div_cnt_r <= samp_stb ? `RST_BYTE : div_cnt_r + 8'h01;
    end
  end

  // new target address only after the interface is reset
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_live_r <= 7'h00;
      req_r      <= 1'b0;
      ref_r      <= 1'b0;
      {ax_r, ay_r, az_r} <= {3{16'h0000}};
    end else if (ce) begin
      if (aux_if_rst)
        acc_live_r <= acca_r[6:0];
      req_r <= samp_stb & aux_if_en & ~aux_if_rst;
      if (accel_valid && aux_if_en)
        {ax_r, ay_r, az_r} <= {accel_x, accel_y, accel_z};
      ref_r <= acca_r[`REF_CLOCK_OUT_PIN_BIT] & ~ref_r;
    end
  end

  assign accel_read_req    = req_r;
  assign accel_bus_address = acc_live_r;
  assign ref_clock_out_pin = ref_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      {gx_r, gy_r, gz_r, tp_r} <= {4{16'h0000}};
      {axo_r, ayo_r, azo_r}    <= {3{16'h0000}};
    end else if (samp_stb) begin
      gx_r  <= raw_gyro_x - {xbh_r, xbl_r};
      gy_r  <= raw_gyro_y - {ybh_r, ybl_r};
      gz_r  <= raw_gyro_z - {zbh_r, zbl_r};
      tp_r  <= raw_temp;
      {axo_r, ayo_r, azo_r} <= {ax_r, ay_r, az_r};
    end
  end

  assign {gyro_x_out, gyro_y_out, gyro_z_out} = {gx_r, gy_r, gz_r};
  assign {accel_x_out, accel_y_out, accel_z_out} = {axo_r, ayo_r, azo_r};
  assign temp_out    = tp_r;
  assign sample_tick = samp_stb;

  function automatic logic [15:0] word_of(input logic [2:0] i);
    unique case (i)
      3'h7: word_of = tp_r;
      3'h6: word_of = gx_r;
      3'h5: word_of = gy_r;
      3'h4: word_of = gz_r;
      3'h3: word_of = axo_r;
      3'h2: word_of = ayo_r;
      3'h1: word_of = azo_r;
      3'h0: word_of = TRAILER;
    endcase
  endfunction

  wire [15:0] seq_word = word_of(seq_bit_r);
  wire        seq_hit  = seq_act_r & seq_sel_r[seq_bit_r];
  wire [7:0]  push_b   = seq_lo_r ? seq_word[7:0] : seq_word[15:8];
  wire        full     = cnt_r == 10'(DEPTH);
  wire        empty    = cnt_r == 10'h000;
  wire        push     = ce & seq_hit & ~full;
  wire        pop      = ce & fifo_rd & ~empty;

  // the group walks select bits from 7 down, one byte per cycle on a selected bit, one idle cycle per skipped bit
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_act_r <= 1'b0;
      seq_lo_r  <= 1'b0;
      seq_bit_r <= `TOP_SEL;
      seq_sel_r <= `RST_BYTE;
    end else if (ce) begin
      if (samp_stb) begin
        seq_act_r <= 1'b1;
        seq_sel_r <= fsel_r;
        seq_bit_r <= `TOP_SEL;
        seq_lo_r  <= 1'b0;
      end else if (seq_act_r) begin
        if (seq_hit && !seq_lo_r)
          seq_lo_r <= 1'b1;
        else begin
          seq_lo_r  <= 1'b0;
          seq_bit_r <= seq_bit_r - 3'h1;
          if (seq_bit_r == 3'h0)
            seq_act_r <= 1'b0;
        end
      end
    end
  end

  // on overflow the newest byte is dropped and the sticky flag rises
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= 10'h000;
      rdata_r <= `RST_BYTE;
      ovf_r   <= 1'b0;
    end else if (ce) begin
      if (push) begin
        mem[wp_r] <= push_b;
        wp_r      <= wp_r + 1'b1;
      end
      if (pop) begin
        rdata_r <= mem[rp_r];
        rp_r    <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + 10'(push) - 10'(pop);
      if (seq_hit && full)
        ovf_r <= 1'b1;
    end
  end

  assign fifo_rdata    = rdata_r;
  assign fifo_count    = cnt_r;
  assign fifo_overflow = ovf_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_id_msb_zero: assert property (!id_r[`ID_MSB])
    else $error("identity bit 7 not zero");
  a_ptr_stop_hold: assert property (
    (ce && scl_fall && st_r == gyro_pkg::ST_RDATA &&
     bits_r == `LAST_TX_BIT && ptr_r == `PTR_STOP_A && !start_c &&
     !stop_c) |=> ptr_r == `PTR_STOP_A)
    else $error("burst pointer passed stop register");
  a_bias_subtract: assert property (
    samp_stb |=> gyro_x_out == $past(raw_gyro_x) - $past({xbh_r, xbl_r}))
    else $error("bias not removed from x sample");
  a_req_gated: assert property (
    accel_read_req |-> $past(aux_if_en) && $past(samp_stb) &&
    !$past(aux_if_rst))
    else $error("accel read without interface enable");
  a_addr_after_rst: assert property (
    !$stable(accel_bus_address) |-> $past(aux_if_rst))
    else $error("accel address changed without reset");
  a_ref_clock_out_pin_off: assert property (
    (ce && !acca_r[`REF_CLOCK_OUT_PIN_BIT]) |=> !ref_clock_out_pin)
    else $error("reference clock runs while disabled");
  a_group_done: assert property (
    (samp_stb && ce) |=> ##[1:17] !seq_act_r)
    else $error("buffer group not finished in time");
  a_level_clean: assert property (
    (level_r & ~(8'h01 << `LEVEL_BIT)) == 8'h00)
    else $error("level register holds stray bits");
  a_fifo_bound: assert property (cnt_r <= 10'(DEPTH))
    else $error("buffer count above depth");
  a_filt_top_zero: assert property (filt_r[7:5] == 3'h0)
    else $error("filter register top bits set");
endmodule

// ---- verilog/gyro_defs.svh ----
// Purpose: shared constants of the gyro configuration register bank
// Assumes: byte-wide register map reached over the primary serial bus
// Notes:   offsets are the register numbers the host uses
`ifndef GYRO_DEFS_SVH
`define GYRO_DEFS_SVH

`define OFS_ID          8'h00
`define OFS_XBH         8'h0c
`define OFS_XBL         8'h0d
`define OFS_YBH         8'h0e
`define OFS_YBL         8'h0f
`define OFS_ZBH         8'h10
`define OFS_ZBL         8'h11
`define OFS_FSEL        8'h12
`define OFS_LEVEL       8'h13
`define OFS_ACCA        8'h14
`define OFS_DIV         8'h15
`define OFS_FILT        8'h16
`define PTR_STOP_A      8'h39
`define PTR_STOP_B      8'h3c

`define RST_BYTE        8'h00
`define ID_MSB          7
`define LEVEL_BIT       2
`define REF_CLOCK_OUT_PIN_BIT      7
`define FILT_MASK       8'h1f
`define FILT_8K         3'h0
`define BYTE_BITS       4'h8
`define LAST_TX_BIT     4'h7
`define TOP_SEL         3'h7

`define CLK_HZ          25000000
`define RATE_1K_HZ      1000
`define RATE_8K_HZ      8000
`define FIFO_BYTES      512

`endif

// ---- verilog/gyro_pkg.sv ----
// Purpose: types of the gyro configuration register bank
// Assumes: nothing beyond the defs header
// Notes:   serial slave states only
package gyro_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } ser_state_e;
endpackage

// ---- test/i2c_host_model.sv ----
// Purpose: host master model of the primary serial bus
// Assumes: open-drain lines with pull-ups; scl stands high between frames
// Notes:   a quarter bit is 2 clk, so one bit takes 320 ns
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic clk,    // bench clock
  input  wire logic sda,    // resolved data wire
  output logic      scl,    // serial clock
  output logic      sda_low // 1 pulls the data wire low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (2) @(negedge clk);
  endtask
  // data moves only mid-low, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
  endtask
  task automatic start();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] d[$], output logic ok);
    logic a;
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(ptr, a);
    ok = ok & a;
    foreach (d[i]) begin
      wbyte(d[i], a);
      ok = ok & a;
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    input int n, output logic [7:0] d[$],
                    output logic ok);
    logic       a;
    logic [7:0] b;
    d = {};
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(ptr, a);
    ok = ok & a;
    start();
    wbyte({dev, 1'b1}, a);
    ok = ok & a;
    for (int i = 0; i < n; i++) begin
      rbyte(i == n - 1, b);
      d.push_back(b);
    end
    stop();
  endtask
endmodule

// ---- test/test_gyro_cfg_regs.sv ----
// Purpose: self-checking bench of the gyro configuration registers
// Assumes: host model on the serial bus, accel answered by the bench
// Notes:   internal ticks shortened to 40 and 20 clk; a full buffer
//          group takes up to 17 clk, so a tick may not come sooner
`timescale 1ns/10ps
module test_gyro_cfg_regs;
  localparam int C1K = 40;
  localparam int C8K = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        aux_if_en = 1'b0;
  logic        aux_if_rst = 1'b0;
  logic        accel_valid = 1'b0;
  logic        fifo_rd = 1'b0;
  logic        scl, sda, sda_low, sda_out, sda_oe_n;
  logic        accel_read_req, sample_tick, fifo_overflow;
  logic        secondary_level_select, ref_clock_out_pin;
  logic [15:0] raw_gyro_x = 16'h1000;
  logic [15:0] raw_gyro_y = 16'h0005;
  logic [15:0] raw_gyro_z = 16'h0000;
  logic [15:0] raw_temp = 16'h1234;
  logic [15:0] accel_x = 16'ha1b2;
  logic [15:0] accel_y = 16'hc3d4;
  logic [15:0] accel_z = 16'he5f6;
  logic [15:0] gyro_x_out, gyro_y_out, gyro_z_out, temp_out;
  logic [15:0] accel_x_out, accel_y_out, accel_z_out;
  logic [6:0]  accel_bus_address;
  logic [7:0]  fifo_rdata;
  logic [9:0]  fifo_count;
  logic [1:0]  range_select;
  logic [2:0]  filter_select;
  logic [6:0]  dev = 7'h54;
  int          fail_count = 0;
  int          n_tests = 0;
  int          n_req = 0;

  assign sda = !(sda_low || !sda_oe_n);
  always #20 clk = !clk;
  // the accelerometer side answers each request one cycle later
  always @(negedge clk) accel_valid <= accel_read_req;
  // counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk) if (accel_read_req === 1'b1) n_req++;

  i2c_host_model i_i2c_host_model (.clk, .sda, .scl, .sda_low);
  gyro_cfg_regs #(.CYC_1K(C1K), .CYC_8K(C8K)) i_gyro_cfg_regs (
    .clk, .rst, .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe_n, .addr_lsb_in(1'b0), .raw_gyro_x, .raw_gyro_y,
    .raw_gyro_z, .raw_temp, .aux_if_en, .aux_if_rst, .accel_valid,
    .accel_x, .accel_y, .accel_z, .accel_read_req, .accel_bus_address,
    .gyro_x_out, .gyro_y_out, .gyro_z_out, .temp_out, .accel_x_out,
    .accel_y_out, .accel_z_out, .sample_tick, .fifo_rd, .fifo_rdata,
    .fifo_count, .fifo_overflow, .range_select, .filter_select,
    .secondary_level_select, .ref_clock_out_pin);

  task automatic chk(input string what, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (k > 20000) begin
        chk("tick wait", 16'h0001, 16'h0000);
        test_done();
      end
    end while (sample_tick !== 1'b1);
  endtask
  task automatic wr1(input logic [7:0] ptr, input logic [7:0] v);
    logic ok;
    i_i2c_host_model.wr(dev, ptr, {v}, ok);
    chk("write ack", 16'h0001, {15'h0000, ok});
  endtask
  task automatic rd1(input logic [7:0] ptr, input logic [7:0] exp);
    logic       ok;
    logic [7:0] d[$];
    i_i2c_host_model.rd(dev, ptr, 1, d, ok);
    chk("read ack", 16'h0001, {15'h0000, ok});
    chk($sformatf("reg %h", ptr), {8'h00, exp}, {8'h00, d[0]});
  endtask

  task automatic t_reset();
    rd1(8'h00, 8'h54);
    rd1(8'h12, 8'h00);
    rd1(8'h13, 8'h00);
    rd1(8'h16, 8'h00);
    chk("sda drive level", 16'h0000, {15'h0000, sda_out});
    wr1(8'h30, 8'h00);
    rd1(8'h30, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ident();
    logic       ok;
    logic [7:0] d[$];
    wr1(8'h00, 8'h2c);
    dev = 7'h2c;
    rd1(8'h00, 8'h2c);
    i_i2c_host_model.rd(7'h54, 8'h00, 1, d, ok);
    chk("old address ack", 16'h0000, {15'h0000, ok});
    wr1(8'h00, 8'h54);
    dev = 7'h54;
    rd1(8'h00, 8'h54);
    $display("test identity done");
  endtask
  task automatic t_burst();
    logic       ok;
    logic [7:0] d[$];
    logic [7:0] b[$] = '{8'h01, 8'h23, 8'hff, 8'hfe, 8'h80, 8'h00};
    i_i2c_host_model.wr(dev, 8'h0c, b, ok);
    chk("burst write ack", 16'h0001, {15'h0000, ok});
    i_i2c_host_model.rd(dev, 8'h0c, 6, d, ok);
    foreach (b[i]) chk("burst byte", {8'h00, b[i]}, {8'h00, d[i]});
    // the pointer must hold at the stop register for the third byte
    i_i2c_host_model.rd(dev, 8'h38, 3, d, ok);
    chk("stop read ack", 16'h0001, {15'h0000, ok});
    foreach (d[i]) chk("stop byte", 16'h0000, {8'h00, d[i]});
    $display("test burst done");
  endtask
  task automatic t_rate();
    int         k;
    logic [7:0] dv[4] = '{8'd3, 8'd0, 8'd255, 8'd0};
    logic [7:0] fl[4] = '{8'h01, 8'h00, 8'h00, 8'h07};
    int         p[4] = '{4 * C1K, C8K, 256 * C8K, C1K};
    for (int i = 0; i < 4; i++) begin
      wr1(8'h15, dv[i]);
      wr1(8'h16, fl[i]);
      wait_tick(k);
      wait_tick(k);
      chk("sample period", 16'(p[i]), 16'(k));
    end
    chk("gyro x out", 16'h0edd, gyro_x_out);
    chk("gyro y out", 16'h0007, gyro_y_out);
    chk("gyro z out", 16'h8000, gyro_z_out);
    chk("temp out", raw_temp, temp_out);
    $display("test rate done");
  endtask
  task automatic t_fifo();
    int          k;
    logic [15:0] w[8];
    w = '{raw_temp, 16'h0edd, 16'h0007, 16'h8000, accel_x, accel_y,
          accel_z, 16'h0000};
    aux_if_en = 1'b1;
    wr1(8'h15, 8'd255);
    wr1(8'h16, 8'h00);
    wait_tick(k);
    wr1(8'h12, 8'hff);
    wait_tick(k);
    // cleared before the next tick so only one group is held
    wr1(8'h12, 8'h00);
    chk("buffer count", 16'd16, {6'h00, fifo_count});
    for (int i = 0; i < 16; i++) begin
      fifo_rd = 1'b1;
      @(negedge clk);
      fifo_rd = 1'b0;
      @(negedge clk);
      chk("buffer byte", i % 2 ? w[i / 2] & 16'h00ff : w[i / 2] >> 8,
          {8'h00, fifo_rdata});
    end
    chk("buffer empty", 16'd0, {6'h00, fifo_count});
    chk("no overflow", 16'h0000, {15'h0000, fifo_overflow});
    chk("accel x out", accel_x, accel_x_out);
    chk("accel y out", accel_y, accel_y_out);
    chk("accel z out", accel_z, accel_z_out);
    chk("read requests", 16'h0001, {15'h0000, n_req > 0});
    // fast ticks with every reading selected overrun the buffer
    wr1(8'h15, 8'h00);
    wr1(8'h12, 8'hff);
    repeat (720) @(negedge clk);
    chk("buffer full", 16'h0200, {6'h00, fifo_count});
    chk("overflow", 16'h0001, {15'h0000, fifo_overflow});
    wr1(8'h12, 8'h00);
    $display("test buffer done");
  endtask
  task automatic t_aux();
    int   k;
    int   n0;
    logic s;
    wr1(8'h14, 8'h9d);
    chk("address held", 16'h0000, {9'h000, accel_bus_address});
    aux_if_rst = 1'b1;
    @(negedge clk);
    aux_if_rst = 1'b0;
    @(negedge clk);
    chk("address", 16'h001d, {9'h000, accel_bus_address});
    s = ref_clock_out_pin;
    @(negedge clk);
    chk("ref clock", {15'h0000, !s}, {15'h0000, ref_clock_out_pin});
    wr1(8'h14, 8'h1d);
    rd1(8'h14, 8'h1d);
    repeat (2) begin
      @(negedge clk);
      chk("ref clock off", 16'h0000, {15'h0000, ref_clock_out_pin});
    end
    aux_if_en = 1'b0;
    wait_tick(k);
    repeat (2) @(negedge clk);
    n0 = n_req;
    wait_tick(k);
    wait_tick(k);
    repeat (2) @(negedge clk);
    chk("requests while off", 16'(n0), 16'(n_req));
    $display("test secondary done");
  endtask
  task automatic t_fields();
    wr1(8'h13, 8'h04);
    chk("level", 16'h0001, {15'h0000, secondary_level_select});
    rd1(8'h13, 8'h04);
    wr1(8'h13, 8'h00);
    chk("level", 16'h0000, {15'h0000, secondary_level_select});
    for (int i = 0; i < 8; i++) begin
      wr1(8'h16, {3'b000, 2'(i), 3'(i)});
      chk("range", 16'(i % 4), {14'h0000, range_select});
      chk("filter", 16'(i), {13'h0000, filter_select});
    end
    // the host keeps the must-be-zero top bits clear
    wr1(8'h16, 8'h1f);
    rd1(8'h16, 8'h1f);
    wr1(8'h16, 8'h00);
    $display("test fields done");
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_ident();
    t_burst();
    t_rate();
    t_fifo();
    t_aux();
    t_fields();
    test_done();
  end
endmodule
